// file: rtl/dtc_regs.sv
// Local design decision: register access over AHB-Lite.
module dtc_regs
  import dtc_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5A, // Arbitrary identification value
  parameter int SAMPLE_WIDTH = 16
) (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Sample path
  input wire logic [SAMPLE_WIDTH-1:0] I_SAMPLE,
  input wire logic [SAMPLE_WIDTH-1:0] Q_SAMPLE,
  output logic [SAMPLE_WIDTH-1:0] I_SAMPLE_OUT,
  output logic [SAMPLE_WIDTH-1:0] Q_SAMPLE_OUT,
  // Configuration to analog and datapath
  output dtc_config_type CONFIG
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] datapath_config_reg;
  logic [7:0] i_phase_low_reg;
  logic [7:0] i_phase_high_reg;
  logic [7:0] q_phase_low_reg;
  logic [7:0] q_phase_high_reg;
  logic [7:0] i_offset_low_reg;
  logic [7:0] i_offset_high_reg;
  logic [7:0] q_offset_low_reg;
  logic [7:0] q_offset_high_reg;
  logic [7:0] i_fullscale_low_reg;
  logic [7:0] i_converter_control_reg;
  logic [7:0] i_aux_low_reg;
  logic [7:0] i_aux_control_reg;
  logic [7:0] q_fullscale_low_reg;
  // Upper Q full-scale bits live in the next register, outside this bank
  logic [1:0] q_fullscale_high;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture
  logic wr_pend_reg;
  logic [7:0] wr_index_reg;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic [7:0] rd_byte;
  logic [7:0] addr_index;
  logic addr_phase;
  logic addr_aligned;

  // Word index from byte address; upper address bits must be zero
  assign addr_index = HADDR[9:2];
  assign addr_aligned = (HADDR[1:0] == 2'h0) && (HADDR[31:10] == 22'h0);
  assign addr_phase = HSEL && HREADY && (HTRANS == DTC_HTRANS_NONSEQ || HTRANS == DTC_HTRANS_SEQ);
  assign q_fullscale_high = DTC_RST_Q_FULLSCALE_HIGH[1:0];

  // Read mux, unmapped indices read as zero
  always_comb begin
    case (addr_index)
      DTC_IDX_DATAPATH_CONFIG: rd_byte = datapath_config_reg;
      DTC_IDX_PART_IDENTIFIER: rd_byte = PART_ID;
      DTC_IDX_I_PHASE_TRIM_LOW: rd_byte = i_phase_low_reg;
      DTC_IDX_I_PHASE_TRIM_HIGH: rd_byte = i_phase_high_reg;
      DTC_IDX_Q_PHASE_TRIM_LOW: rd_byte = q_phase_low_reg;
      DTC_IDX_Q_PHASE_TRIM_HIGH: rd_byte = q_phase_high_reg;
      DTC_IDX_I_SAMPLE_OFFSET_LOW: rd_byte = i_offset_low_reg;
      DTC_IDX_I_SAMPLE_OFFSET_HIGH: rd_byte = i_offset_high_reg;
      DTC_IDX_Q_SAMPLE_OFFSET_LOW: rd_byte = q_offset_low_reg;
      DTC_IDX_Q_SAMPLE_OFFSET_HIGH: rd_byte = q_offset_high_reg;
      DTC_IDX_I_FULLSCALE_LOW: rd_byte = i_fullscale_low_reg;
      DTC_IDX_I_CONVERTER_CONTROL: rd_byte = i_converter_control_reg;
      DTC_IDX_I_AUX_MAGNITUDE_LOW: rd_byte = i_aux_low_reg;
      DTC_IDX_I_AUX_CONTROL: rd_byte = i_aux_control_reg;
      DTC_IDX_Q_FULLSCALE_LOW: rd_byte = q_fullscale_low_reg;
      default: rd_byte = DTC_RST_ZERO;
    endcase
    rd_data_next = (addr_phase && !HWRITE && addr_aligned) ? {24'h0, rd_byte} : 32'h0;
  end

  // Bus pipeline: zero wait states, always OKAY
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wr_pend_reg <= 1'b0;
      wr_index_reg <= 8'h00;
      rd_data_reg <= 32'h0;
    end else if (CE) begin
      wr_pend_reg <= addr_phase && HWRITE && addr_aligned;
      wr_index_reg <= addr_index;
      rd_data_reg <= rd_data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode in data phase
  logic [7:0] wbyte;
  logic wr_now;
  assign wbyte = HWDATA[7:0];
  assign wr_now = wr_pend_reg && CE;

  logic [7:0] wdata_cfg;
  logic [7:0] wdata_trim_hi;
  logic [7:0] wdata_conv_ctl;
  logic [7:0] wdata_aux_ctl;
  assign wdata_cfg = wbyte & DTC_MASK_DATAPATH_CONFIG;
  assign wdata_trim_hi = wbyte & DTC_MASK_TRIM_HIGH;
  assign wdata_conv_ctl = wbyte & DTC_MASK_I_CONVERTER_CONTROL;
  assign wdata_aux_ctl = wbyte & DTC_MASK_I_AUX_CONTROL;

  // Register writes; the identifier has no write path
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      datapath_config_reg <= DTC_RST_ZERO;
      i_phase_low_reg <= DTC_RST_ZERO;
      i_phase_high_reg <= DTC_RST_ZERO;
      q_phase_low_reg <= DTC_RST_ZERO;
      q_phase_high_reg <= DTC_RST_ZERO;
      i_offset_low_reg <= DTC_RST_ZERO;
      i_offset_high_reg <= DTC_RST_ZERO;
      q_offset_low_reg <= DTC_RST_ZERO;
      q_offset_high_reg <= DTC_RST_ZERO;
      i_fullscale_low_reg <= DTC_RST_FULLSCALE_LOW;
      i_converter_control_reg <= DTC_RST_I_CONVERTER_CONTROL;
      i_aux_low_reg <= DTC_RST_ZERO;
      i_aux_control_reg <= DTC_RST_ZERO;
      q_fullscale_low_reg <= DTC_RST_FULLSCALE_LOW;
    end else if (wr_now) begin
      case (wr_index_reg)
        DTC_IDX_DATAPATH_CONFIG: datapath_config_reg <= wdata_cfg;
        DTC_IDX_I_PHASE_TRIM_LOW: i_phase_low_reg <= wbyte;
        DTC_IDX_I_PHASE_TRIM_HIGH: i_phase_high_reg <= wdata_trim_hi;
        DTC_IDX_Q_PHASE_TRIM_LOW: q_phase_low_reg <= wbyte;
        DTC_IDX_Q_PHASE_TRIM_HIGH: q_phase_high_reg <= wdata_trim_hi;
        DTC_IDX_I_SAMPLE_OFFSET_LOW: i_offset_low_reg <= wbyte;
        DTC_IDX_I_SAMPLE_OFFSET_HIGH: i_offset_high_reg <= wbyte;
        DTC_IDX_Q_SAMPLE_OFFSET_LOW: q_offset_low_reg <= wbyte;
        DTC_IDX_Q_SAMPLE_OFFSET_HIGH: q_offset_high_reg <= wbyte;
        DTC_IDX_I_FULLSCALE_LOW: i_fullscale_low_reg <= wbyte;
        DTC_IDX_I_CONVERTER_CONTROL: i_converter_control_reg <= wdata_conv_ctl;
        DTC_IDX_I_AUX_MAGNITUDE_LOW: i_aux_low_reg <= wbyte;
        DTC_IDX_I_AUX_CONTROL: i_aux_control_reg <= wdata_aux_ctl;
        DTC_IDX_Q_FULLSCALE_LOW: q_fullscale_low_reg <= wbyte;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field assembly
  dtc_config_type config_next;
  always_comb begin
    config_next.datapath_enable = datapath_config_reg[DTC_POS_DATAPATH_ENABLE];
    config_next.i_phase_trim = {i_phase_high_reg[1:0], i_phase_low_reg};
    config_next.q_phase_trim = {q_phase_high_reg[1:0], q_phase_low_reg};
    config_next.i_sample_offset = {i_offset_high_reg, i_offset_low_reg};
    config_next.q_sample_offset = {q_offset_high_reg, q_offset_low_reg};
    config_next.i_fullscale_code = {i_converter_control_reg[1:0], i_fullscale_low_reg};
    config_next.i_converter_sleep = i_converter_control_reg[DTC_POS_CONVERTER_SLEEP];
    config_next.i_aux_negative = i_aux_control_reg[DTC_POS_AUX_SIGN];
    config_next.i_aux_sink = i_aux_control_reg[DTC_POS_AUX_DIRECTION];
    config_next.i_aux_sleep = i_aux_control_reg[DTC_POS_AUX_SLEEP];
    config_next.i_aux_magnitude = {i_aux_control_reg[1:0], i_aux_low_reg};
    config_next.q_fullscale_code = {q_fullscale_high, q_fullscale_low_reg};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample offset adders; wrap on overflow, no saturation to keep it one cycle
  logic [SAMPLE_WIDTH-1:0] i_sum;
  logic [SAMPLE_WIDTH-1:0] q_sum;
  assign i_sum = SAMPLE_WIDTH'(I_SAMPLE + config_next.i_sample_offset);
  assign q_sum = SAMPLE_WIDTH'(Q_SAMPLE + config_next.q_sample_offset);

  // Registered outputs
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      I_SAMPLE_OUT <= '0;
      Q_SAMPLE_OUT <= '0;
      CONFIG <= '0;
    end else if (CE) begin
      I_SAMPLE_OUT <= i_sum;
      Q_SAMPLE_OUT <= q_sum;
      CONFIG <= config_next;
    end
  end

  // Bus answer lines
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  assign HRDATA = rd_data_reg;

endmodule // dtc_regs

// file: rtl/dtc_pkg.sv
package dtc_pkg;

  // Register offsets (word indices; byte address is four times the index)
  localparam logic [7:0] DTC_IDX_DATAPATH_CONFIG = 8'h1E;
  localparam logic [7:0] DTC_IDX_PART_IDENTIFIER = 8'h1F;
  localparam logic [7:0] DTC_IDX_I_PHASE_TRIM_LOW = 8'h38;
  localparam logic [7:0] DTC_IDX_I_PHASE_TRIM_HIGH = 8'h39;
  localparam logic [7:0] DTC_IDX_Q_PHASE_TRIM_LOW = 8'h3A;
  localparam logic [7:0] DTC_IDX_Q_PHASE_TRIM_HIGH = 8'h3B;
  localparam logic [7:0] DTC_IDX_I_SAMPLE_OFFSET_LOW = 8'h3C;
  localparam logic [7:0] DTC_IDX_I_SAMPLE_OFFSET_HIGH = 8'h3D;
  localparam logic [7:0] DTC_IDX_Q_SAMPLE_OFFSET_LOW = 8'h3E;
  localparam logic [7:0] DTC_IDX_Q_SAMPLE_OFFSET_HIGH = 8'h3F;
  localparam logic [7:0] DTC_IDX_I_FULLSCALE_LOW = 8'h40;
  localparam logic [7:0] DTC_IDX_I_CONVERTER_CONTROL = 8'h41;
  localparam logic [7:0] DTC_IDX_I_AUX_MAGNITUDE_LOW = 8'h42;
  localparam logic [7:0] DTC_IDX_I_AUX_CONTROL = 8'h43;
  localparam logic [7:0] DTC_IDX_Q_FULLSCALE_LOW = 8'h44;

  // Writable bit masks per register
  localparam logic [7:0] DTC_MASK_DATAPATH_CONFIG = 8'h01;
  localparam logic [7:0] DTC_MASK_TRIM_HIGH = 8'h03;
  localparam logic [7:0] DTC_MASK_I_CONVERTER_CONTROL = 8'h83;
  localparam logic [7:0] DTC_MASK_I_AUX_CONTROL = 8'hE3;

  // Field positions
  localparam int DTC_POS_DATAPATH_ENABLE = 0;
  localparam int DTC_POS_CONVERTER_SLEEP = 7;
  localparam int DTC_POS_AUX_SIGN = 7;
  localparam int DTC_POS_AUX_DIRECTION = 6;
  localparam int DTC_POS_AUX_SLEEP = 5;

  // Reset values
  localparam logic [7:0] DTC_RST_ZERO = 8'h00;
  localparam logic [7:0] DTC_RST_FULLSCALE_LOW = 8'hF9;
  localparam logic [7:0] DTC_RST_I_CONVERTER_CONTROL = 8'h01;
  localparam logic [7:0] DTC_RST_Q_FULLSCALE_HIGH = 8'h01;

  // AHB-Lite encodings
  localparam logic [1:0] DTC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DTC_HTRANS_SEQ = 2'h3;

  // Analog-facing configuration bundle
  typedef struct packed {
    logic datapath_enable;
    logic [9:0] i_phase_trim;
    logic [9:0] q_phase_trim;
    logic [15:0] i_sample_offset;
    logic [15:0] q_sample_offset;
    logic [9:0] i_fullscale_code;
    logic i_converter_sleep;
    logic i_aux_negative;
    logic i_aux_sink;
    logic i_aux_sleep;
    logic [9:0] i_aux_magnitude;
    logic [9:0] q_fullscale_code;
  } dtc_config_type;

endpackage : dtc_pkg

// file: testbench/dtc_regs_monitor.sv
module dtc_regs_monitor
  import dtc_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5A, // Arbitrary value
  parameter int SAMPLE_WIDTH = 16
) (
  // Clock and control
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Samples and settings
  input wire logic [SAMPLE_WIDTH-1:0] I_SAMPLE,
  input wire logic [SAMPLE_WIDTH-1:0] Q_SAMPLE,
  input wire logic [SAMPLE_WIDTH-1:0] I_SAMPLE_OUT,
  input wire logic [SAMPLE_WIDTH-1:0] Q_SAMPLE_OUT,
  input wire dtc_config_type CONFIG
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // Accepted address phase
  wire logic take = HSEL && HREADY && HTRANS[1] && CE;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  // Bus never stalls and never errors
  AST_ALWAYS_OKAY: assert property (HREADYOUT && !HRESP) else $error("bus stalled or errored");
  AST_UPPER_ZERO: assert property (HRDATA[31:8] == 24'h0) else $error("upper read lanes set");
  AST_IDLE_ZERO: assert property (!$past(take && !HWRITE) |-> HRDATA == 32'h0) else $error("read data outside phase");
  AST_ID_READ: assert property (take && !HWRITE && HADDR == 32'h7C |=> HRDATA[7:0] == PART_ID)
    else $error("identifier wrong");
  AST_TRIM_SPARE: assert property (take && !HWRITE && (HADDR == 32'hE4 || HADDR == 32'hEC)
    |=> HRDATA[7:2] == 6'h0) else $error("spare trim bits set");
  AST_I_OFFSET: assert property (CE && $past(CE) && !$past(RST) && $stable(CONFIG.i_sample_offset)
    |-> I_SAMPLE_OUT == SAMPLE_WIDTH'($past(I_SAMPLE) + CONFIG.i_sample_offset)) else $error("I offset wrong");
  AST_Q_OFFSET: assert property (CE && $past(CE) && !$past(RST) && $stable(CONFIG.q_sample_offset)
    |-> Q_SAMPLE_OUT == SAMPLE_WIDTH'($past(Q_SAMPLE) + CONFIG.q_sample_offset)) else $error("Q offset wrong");
  AST_CONFIG_CAUSE: assert property ($changed(CONFIG) && !$past(RST) && !$past(RST, 2)
    |-> $past(take && HWRITE, 2) || $past(take && HWRITE, 3)) else $error("settings changed unprompted");
endmodule // dtc_regs_monitor

bind dtc_regs dtc_regs_monitor #(.PART_ID(PART_ID), .SAMPLE_WIDTH(SAMPLE_WIDTH)) u_mon (
  .MCLK(MCLK), .RST(RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .I_SAMPLE(I_SAMPLE), .Q_SAMPLE(Q_SAMPLE), .I_SAMPLE_OUT(I_SAMPLE_OUT),
  .Q_SAMPLE_OUT(Q_SAMPLE_OUT), .CONFIG(CONFIG));

// file: testbench/dtc_regs_tb_top.sv
module dtc_regs_tb_top
  import dtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID_CODE = 8'h3C; // Arbitrary value
  localparam logic [7:0] IDX [15] = '{8'h1E, 8'h1F, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D,
    8'h3E, 8'h3F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44};
  localparam logic [7:0] RSTV [15] = '{8'h00, ID_CODE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hF9, 8'h01, 8'h00, 8'h00, 8'hF9};
  localparam logic [7:0] MSK [15] = '{8'h01, ID_CODE, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'h83, 8'hFF, 8'hE3, 8'hFF};
  localparam logic [7:0] VAL [15] = '{8'h01, 8'h00, 8'h5A, 8'h02, 8'hA5, 8'h01, 8'h34, 8'h12,
    8'hCD, 8'hAB, 8'h00, 8'h82, 8'h11, 8'hA2, 8'h3C};
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [15:0] I_SAMPLE = 16'h0;
  logic [15:0] Q_SAMPLE = 16'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic [15:0] I_SAMPLE_OUT;
  logic [15:0] Q_SAMPLE_OUT;
  dtc_config_type CONFIG;
  int n_fail = 0;
  int checks = 0;
  ////////////////////////////////////////
  // 125 MHz clock
  always #4 MCLK = ~MCLK;
  // Ready loops back; size held fixed, enable driven by the bench
  dtc_regs #(.PART_ID(ID_CODE), .SAMPLE_WIDTH(16)) DUT (
    .MCLK(MCLK), .RST(RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .I_SAMPLE(I_SAMPLE), .Q_SAMPLE(Q_SAMPLE), .I_SAMPLE_OUT(I_SAMPLE_OUT),
    .Q_SAMPLE_OUT(Q_SAMPLE_OUT), .CONFIG(CONFIG));
  ////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One edge with ready high, bounded so a hang ends the run
  task automatic step;
    int n;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 50);
    if (HREADYOUT !== 1'b1) begin
      n_fail++;
      close_out();
    end
  endtask
  // Single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {22'h0, idx, 2'h0};
    step();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, d};
    step();
  endtask
  // Read and compare the whole word against the byte, zero-extended
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk($sformatf("register %h", idx), HRDATA, {24'h0, exp});
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      rd(IDX[i], RSTV[i]);
    end
    chk("fullscale", {CONFIG.i_fullscale_code, CONFIG.q_fullscale_code}, {10'h1F9, 10'h1F9});
    rd(8'h20, 8'h00);
    // Spare bits and identifier ignore writes
    for (int i = 0; i < 15; i++) begin
      xfer(1'b1, IDX[i], 8'hFF);
    end
    for (int i = 0; i < 15; i++) begin
      rd(IDX[i], MSK[i]);
    end
    for (int i = 0; i < 15; i++) begin
      xfer(1'b1, IDX[i], VAL[i]);
    end
    xfer(1'b1, 8'h20, 8'hFF);
    I_SAMPLE <= 16'hFFFF;
    Q_SAMPLE <= 16'h0100;
    repeat (3) @(posedge MCLK);
    chk("config", CONFIG, {1'b1, 10'h25A, 10'h1A5, 16'h1234, 16'hABCD, 10'h200, 4'b1101, 10'h211, 10'h13C});
    chk("i sample", I_SAMPLE_OUT, 16'h1233);
    chk("q sample", Q_SAMPLE_OUT, 16'hACCD);
    // Flip sign, direction, sleeps
    xfer(1'b1, 8'h43, 8'h40);
    xfer(1'b1, 8'h41, 8'h03);
    repeat (2) @(posedge MCLK);
    chk("aux", {CONFIG.i_aux_negative, CONFIG.i_aux_sink, CONFIG.i_aux_sleep, CONFIG.i_aux_magnitude}, {3'b010, 10'h011});
    chk("i conv", {CONFIG.i_converter_sleep, CONFIG.i_fullscale_code}, {1'b0, 10'h300});
    // Enable low must freeze the sample pipe
    CE <= 1'b0;
    I_SAMPLE <= 16'h0001;
    repeat (3) @(posedge MCLK);
    chk("frozen i sample", I_SAMPLE_OUT, 16'h1233);
    CE <= 1'b1;
    repeat (2) @(posedge MCLK);
    chk("thawed i sample", I_SAMPLE_OUT, 16'h1235);
    close_out();
  end
endmodule // dtc_regs_tb_top
